// File: rtl/spe_front_end.sv
// Summary of operation
// - input bits are taken on rising serial clock edges in both modes
// - output bits change on falling serial clock edges
// - chip select high floats the output; standby unless a write cycle runs
// - input carries instruction, then address bytes, then data bytes
// - protect pin high never blocks any write
// - protect pin low with enable bit set refuses status writes
// - pause low and resume high with clock low; transfer resumes intact
// - first eight clocked bits after select falls form the instruction
// - only six instruction codes act; all others are ignored
// - set write enable is 06h, clear write enable is 04h
// - array read 03h, status read 05h, status write 01h
// - array write is 02h
// - page select bit steers accesses to the 256-byte identification page
// - lock bit makes the identification page read-only until reset
// - self-timed write ends within 5 ms of select rising
// - set code sets the write enable latch, clear code resets it
// - during a write cycle only status read is honoured
// - busy bit reads 1 during a write cycle, 0 when ready
// - address is 24 bits; only the low 17 are used
module spe_front_end #(
	parameter int unsigned WC_CYCLES = spe_pkg::WRITE_CYCLE_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	input wire logic hold_n_i,
	input wire logic wp_n_i,
	output logic so_o,
	output logic so_oe_n_o,
	output logic arr_rd_o,
	output logic arr_wr_o,
	output logic arr_id_page_o,
	output logic [spe_pkg::ADDR_W-1:0] arr_addr_o,
	output logic [7:0] arr_wdata_o,
	input wire logic [7:0] arr_rdata_i,
	output logic busy_o,
	output logic [7:0] status_o
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [spe_pkg::PIN_N-1:0] s1_q, s1_d, s2_q, s2_d;
	logic sck_prev_q, sck_prev_d, cs_prev_q, cs_prev_d;

	always_comb begin
		s1_d = {wp_n_i, hold_n_i, si_i, sck_i, cs_n_i};
		s2_d = s1_q;
		sck_prev_d = s2_q[1];
		cs_prev_d = s2_q[0];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q <= 5'h1F;
			s2_q <= 5'h1F;
			sck_prev_q <= 1'b0;
			cs_prev_q <= 1'b1;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			sck_prev_q <= sck_prev_d;
			cs_prev_q <= cs_prev_d;
		end
	end

	logic cs_n, sck, si, hold_n, wp_n;
	assign cs_n = s2_q[0];
	assign sck = s2_q[1];
	assign si = s2_q[2];
	assign hold_n = s2_q[3];
	assign wp_n = s2_q[4];

	// ----------------------------------------------------------------
	// command engine
	// ----------------------------------------------------------------
	spe_pkg::spe_phase_t phase_q, phase_d;
	logic paused_q, paused_d, cmd_done_q, cmd_done_d, st_got_q, st_got_d;
	logic wrote_q, wrote_d, wr_ok_q, wr_ok_d, touched_q, touched_d;
	logic wel_q, wel_d, pen_q, pen_d, page_q, page_d, lock_q, lock_d, busy_q, busy_d;
	logic [1:0] bp_q, bp_d, abyte_q, abyte_d;
	logic [2:0] cnt_q, cnt_d;
	logic [7:0] cmd_q, cmd_d, sr_q, sr_d, tx_q, tx_d, st_data_q, st_data_d;
	logic [spe_pkg::ADDR_W-1:0] addr_q, addr_d, next_addr;
	logic [31:0] timer_q, timer_d;
	logic so_q, so_d, oe_n_q, oe_n_d, rd_q, rd_d, wr_q, wr_d, idp_q, idp_d;
	logic [spe_pkg::ADDR_W-1:0] aout_q, aout_d;
	logic [7:0] wdata_q, wdata_d;
	logic rise, fall, cs_rise, byte_done, guarded;
	logic [7:0] rx, status;

	function automatic logic blk_prot(input logic [1:0] bp, input logic [16:0] a);
		case (bp)
			2'h0: blk_prot = 1'b0;
			2'h1: blk_prot = a[16] & a[15];
			2'h2: blk_prot = a[16];
			default: blk_prot = 1'b1;
		endcase
	endfunction

	always_comb begin
		status = 8'h00;
		status[spe_pkg::ST_BUSY] = busy_q;
		status[spe_pkg::ST_WEL] = wel_q;
		status[spe_pkg::ST_BP_HI:spe_pkg::ST_BP_LO] = bp_q;
		status[spe_pkg::ST_LOCK] = lock_q;
		status[spe_pkg::ST_PAGE] = page_q;
		status[spe_pkg::ST_PEN] = pen_q;
		// a pause freezes edge detection, so no bit is lost or repeated
		rise = sck & ~sck_prev_q & ~cs_n & ~paused_q;
		fall = ~sck & sck_prev_q & ~cs_n & ~paused_q;
		cs_rise = cs_n & ~cs_prev_q;
		rx = {sr_q[6:0], si};
		byte_done = rise && (cnt_q == spe_pkg::BIT_LAST);
		// identification page wraps within 256 bytes
		next_addr = page_q ? {addr_q[16:8], addr_q[7:0] + 8'h01} : addr_q + 17'h00001;
		// a pin held high never blocks; low plus enable bit guards status
		guarded = ~wp_n & pen_q;

		phase_d = phase_q;
		paused_d = paused_q;
		cmd_done_d = cmd_done_q;
		st_got_d = st_got_q;
		wrote_d = wrote_q;
		wr_ok_d = wr_ok_q;
		touched_d = touched_q;
		wel_d = wel_q;
		pen_d = pen_q;
		page_d = page_q;
		lock_d = lock_q;
		bp_d = bp_q;
		busy_d = busy_q;
		timer_d = timer_q;
		abyte_d = abyte_q;
		cnt_d = cnt_q;
		cmd_d = cmd_q;
		sr_d = sr_q;
		tx_d = tx_q;
		st_data_d = st_data_q;
		addr_d = addr_q;
		so_d = so_q;
		rd_d = 1'b0;
		wr_d = 1'b0;
		idp_d = idp_q;
		aout_d = aout_q;
		wdata_d = wdata_q;

		if (busy_q) begin
			timer_d = timer_q + 32'h1;
			if (timer_q >= 32'(WC_CYCLES - 1)) begin
				busy_d = 1'b0;
			end
		end

		if (rd_q) begin
			tx_d = arr_rdata_i;
		end

		if (cs_n) begin
			paused_d = 1'b0;
		end else if (~sck && ~hold_n) begin
			paused_d = 1'b1;
		end else if (~sck && hold_n) begin
			paused_d = 1'b0;
		end

		if (rise) begin
			sr_d = rx;
			cnt_d = cnt_q + 3'h1;
		end
		if (fall) begin
			so_d = tx_q[~cnt_q];
		end

		if (byte_done) begin
			case (phase_q)
				spe_pkg::SPE_PH_CMD: begin
					cmd_d = rx;
					cmd_done_d = 1'b1;
					phase_d = spe_pkg::SPE_PH_IGNORE;
					if (~busy_q || rx == spe_pkg::OP_ST_READ) begin
						case (rx)
							spe_pkg::OP_ST_READ: begin
								phase_d = spe_pkg::SPE_PH_DATA;
								tx_d = status;
							end
							spe_pkg::OP_ST_WRITE: phase_d = spe_pkg::SPE_PH_DATA;
							spe_pkg::OP_ARR_READ, spe_pkg::OP_ARR_WRITE: begin
								phase_d = spe_pkg::SPE_PH_ADDR;
								abyte_d = 2'h0;
							end
							default: phase_d = spe_pkg::SPE_PH_IGNORE;
						endcase
					end
				end
				spe_pkg::SPE_PH_ADDR: begin
					addr_d = {addr_q[8:0], rx};
					abyte_d = abyte_q + 2'h1;
					if (abyte_q == spe_pkg::ADDR_LAST_BYTE) begin
						phase_d = spe_pkg::SPE_PH_DATA;
						touched_d = 1'b1;
						wr_ok_d = wel_q & ~blk_prot(bp_q, {addr_q[8:0], rx})
							& ~(page_q & lock_q);
						if (cmd_q == spe_pkg::OP_ARR_READ) begin
							rd_d = 1'b1;
							aout_d = {addr_q[8:0], rx};
							idp_d = page_q;
						end
					end
				end
				spe_pkg::SPE_PH_DATA: begin
					case (cmd_q)
						spe_pkg::OP_ST_READ: tx_d = status;
						spe_pkg::OP_ST_WRITE: begin
							st_data_d = rx;
							st_got_d = 1'b1;
						end
						spe_pkg::OP_ARR_READ: begin
							rd_d = 1'b1;
							aout_d = next_addr;
							addr_d = next_addr;
						end
						spe_pkg::OP_ARR_WRITE: begin
							if (wr_ok_q) begin
								wr_d = 1'b1;
								wrote_d = 1'b1;
								aout_d = addr_q;
								wdata_d = rx;
								idp_d = page_q;
							end
							// page address stays put, byte index rolls over
							addr_d = {addr_q[16:8], addr_q[7:0] + 8'h01};
						end
						default: phase_d = spe_pkg::SPE_PH_IGNORE;
					endcase
				end
				default: phase_d = spe_pkg::SPE_PH_IGNORE;
			endcase
		end

		// latch and status effects only take hold when the frame closes
		if (cs_rise) begin
			if (cmd_done_q && ~busy_q) begin
				case (cmd_q)
					spe_pkg::OP_SET_WE: wel_d = 1'b1;
					spe_pkg::OP_CLR_WE: wel_d = 1'b0;
					spe_pkg::OP_ST_WRITE: begin
						if (st_got_q && wel_q && ~guarded) begin
							pen_d = st_data_q[spe_pkg::ST_PEN];
							bp_d = st_data_q[spe_pkg::ST_BP_HI:spe_pkg::ST_BP_LO];
							if (~(st_data_q[spe_pkg::ST_PAGE] & st_data_q[spe_pkg::ST_LOCK])) begin
								page_d = st_data_q[spe_pkg::ST_PAGE];
								lock_d = lock_q | st_data_q[spe_pkg::ST_LOCK];
							end
							busy_d = 1'b1;
							timer_d = 32'h0;
							wel_d = 1'b0;
						end
					end
					spe_pkg::OP_ARR_WRITE: begin
						if (wrote_q) begin
							busy_d = 1'b1;
							timer_d = 32'h0;
							wel_d = 1'b0;
						end
						if (touched_q) begin
							page_d = 1'b0;
						end
					end
					spe_pkg::OP_ARR_READ: begin
						if (touched_q) begin
							page_d = 1'b0;
						end
					end
					default: wel_d = wel_q;
				endcase
			end
		end
		if (cs_n) begin
			phase_d = spe_pkg::SPE_PH_CMD;
			cnt_d = 3'h0;
			abyte_d = 2'h0;
			cmd_done_d = 1'b0;
			st_got_d = 1'b0;
			wrote_d = 1'b0;
			touched_d = 1'b0;
			wr_ok_d = 1'b0;
		end

		// drive only while reading out, selected and not paused
		oe_n_d = ~(~cs_n & ~paused_d & (phase_q == spe_pkg::SPE_PH_DATA) &
			(cmd_q == spe_pkg::OP_ARR_READ || cmd_q == spe_pkg::OP_ST_READ));
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_q <= spe_pkg::SPE_PH_CMD;
			paused_q <= 1'b0;
			cmd_done_q <= 1'b0;
			st_got_q <= 1'b0;
			wrote_q <= 1'b0;
			wr_ok_q <= 1'b0;
			touched_q <= 1'b0;
			wel_q <= 1'b0;
			pen_q <= 1'b0;
			page_q <= 1'b0;
			lock_q <= 1'b0;
			bp_q <= spe_pkg::BP_RESET;
			busy_q <= 1'b0;
			timer_q <= 32'h0;
			abyte_q <= 2'h0;
			cnt_q <= 3'h0;
			cmd_q <= 8'h00;
			sr_q <= 8'h00;
			tx_q <= 8'h00;
			st_data_q <= 8'h00;
			addr_q <= 17'h00000;
			so_q <= 1'b0;
			oe_n_q <= 1'b1;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			idp_q <= 1'b0;
			aout_q <= 17'h00000;
			wdata_q <= 8'h00;
		end else begin
			phase_q <= phase_d;
			paused_q <= paused_d;
			cmd_done_q <= cmd_done_d;
			st_got_q <= st_got_d;
			wrote_q <= wrote_d;
			wr_ok_q <= wr_ok_d;
			touched_q <= touched_d;
			wel_q <= wel_d;
			pen_q <= pen_d;
			page_q <= page_d;
			lock_q <= lock_d;
			bp_q <= bp_d;
			busy_q <= busy_d;
			timer_q <= timer_d;
			abyte_q <= abyte_d;
			cnt_q <= cnt_d;
			cmd_q <= cmd_d;
			sr_q <= sr_d;
			tx_q <= tx_d;
			st_data_q <= st_data_d;
			addr_q <= addr_d;
			so_q <= so_d;
			oe_n_q <= oe_n_d;
			rd_q <= rd_d;
			wr_q <= wr_d;
			idp_q <= idp_d;
			aout_q <= aout_d;
			wdata_q <= wdata_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign so_o = so_q;
	assign so_oe_n_o = oe_n_q;
	assign arr_rd_o = rd_q;
	assign arr_wr_o = wr_q;
	assign arr_id_page_o = idp_q;
	assign arr_addr_o = aout_q;
	assign arr_wdata_o = wdata_q;
	assign busy_o = busy_q;
	assign status_o = {pen_q, page_q, 1'b0, lock_q, bp_q, wel_q, busy_q};

endmodule

// File: rtl/spe_pkg.sv
package spe_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_KHZ = 40000;
	localparam int WRITE_CYCLE_MS = 5;
	localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_MS * CLK_KHZ;

	// ----------------------------------------------------------------
	// instruction codes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_SET_WE = 8'h06;
	localparam logic [7:0] OP_CLR_WE = 8'h04;
	localparam logic [7:0] OP_ST_READ = 8'h05;
	localparam logic [7:0] OP_ST_WRITE = 8'h01;
	localparam logic [7:0] OP_ARR_READ = 8'h03;
	localparam logic [7:0] OP_ARR_WRITE = 8'h02;

	// ----------------------------------------------------------------
	// status register layout
	// ----------------------------------------------------------------
	localparam int ST_BUSY = 0;
	localparam int ST_WEL = 1;
	localparam int ST_BP_LO = 2;
	localparam int ST_BP_HI = 3;
	localparam int ST_LOCK = 4;
	localparam int ST_PAGE = 6;
	localparam int ST_PEN = 7;
	localparam logic [1:0] BP_RESET = 2'h0;

	// ----------------------------------------------------------------
	// framing
	// ----------------------------------------------------------------
	localparam int ADDR_W = 17;
	localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam int PIN_N = 5;

	typedef enum logic [1:0] {
		SPE_PH_CMD,
		SPE_PH_ADDR,
		SPE_PH_DATA,
		SPE_PH_IGNORE
	} spe_phase_t;

endpackage

// File: testbench/spe_front_end_monitor.sv
module spe_front_end_monitor #(
	parameter int unsigned WC_CYCLES = 50
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cs_n_i,
	input wire logic hold_n_i,
	input wire logic so_oe_n_o,
	input wire logic arr_rd_o,
	input wire logic arr_wr_o,
	input wire logic busy_o,
	input wire logic [7:0] status_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] bcnt_q;
	logic [31:0] bcnt_d;
	always_comb bcnt_d = busy_o ? bcnt_q + 32'h1 : 32'h0;
	always_ff @(posedge clk_i) bcnt_q <= rst_i ? 32'h0 : bcnt_d;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// pin inputs pass a synchroniser, so a few cycles of settling are allowed
	a_cs_float: assert property (cs_n_i [*5] |-> so_oe_n_o)
		else $error("so driven while deselected");
	a_hold_float: assert property (!hold_n_i [*5] |-> so_oe_n_o)
		else $error("so driven while paused");
	a_wr_pulse: assert property (arr_wr_o |=> !arr_wr_o)
		else $error("write strobe too long");
	a_rd_pulse: assert property (arr_rd_o |=> !arr_rd_o)
		else $error("read strobe too long");
	a_wr_gate: assert property (arr_wr_o |-> status_o[spe_pkg::ST_WEL] && !busy_o)
		else $error("write without enable or while busy");
	a_busy_bit: assert property (busy_o |-> ##[0:1] status_o[spe_pkg::ST_BUSY])
		else $error("busy bit not shown");
	a_busy_start: assert property ($rose(busy_o) |-> cs_n_i)
		else $error("write cycle began while selected");
	a_busy_wel: assert property ($rose(status_o[spe_pkg::ST_WEL]) |-> !$past(busy_o))
		else $error("enable latch set during write cycle");
	a_busy_len: assert property ($fell(busy_o) |-> bcnt_q + 4 >= WC_CYCLES
		&& bcnt_q <= WC_CYCLES + 4)
		else $error("write cycle length wrong");
	cover property (arr_wr_o);
	cover property (arr_rd_o);
	cover property ($fell(busy_o));
endmodule

bind spe_front_end spe_front_end_monitor #(.WC_CYCLES(WC_CYCLES)) u_mon (.clk_i, .rst_i,
	.cs_n_i, .hold_n_i, .so_oe_n_o, .arr_rd_o, .arr_wr_o, .busy_o, .status_o);

// File: testbench/spe_front_end_test.sv
module spe_front_end_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned WC = 400;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wp_n_i = 1'b1;
	logic [7:0] arr_rdata_i;
	logic sck_i, cs_n_i, si_i, hold_n_i, so_o, so_oe_n_o, arr_rd_o, arr_wr_o, arr_id_page_o;
	logic busy_o, so_line;
	logic [16:0] arr_addr_o, wr_addr;
	logic [7:0] arr_wdata_o, status_o, r, wr_data;
	int num_errors = 0;
	int total_checks = 0;
	int wr_cnt = 0;
	int cyc = 0;
	always #12.5 clk_i = ~clk_i;
	spe_front_end #(.WC_CYCLES(WC)) u_dut (.clk_i, .rst_i, .sck_i, .cs_n_i, .si_i, .hold_n_i,
		.wp_n_i, .so_o, .so_oe_n_o, .arr_rd_o, .arr_wr_o, .arr_id_page_o, .arr_addr_o,
		.arr_wdata_o, .arr_rdata_i, .busy_o, .status_o);
	spe_host u_host (.clk_i, .so_i(so_line), .sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i),
		.hold_n_o(hold_n_i));
	// read data is latched at the end of the strobe cycle, so the stand-in answers
	// within it; a released output shows the inverse of its last bit
	always_comb arr_rdata_i = arr_rd_o ? (arr_addr_o[7:0] ^ 8'hA5) : 8'h00;
	always_comb so_line = so_oe_n_o ? ~so_o : so_o;
	// writes are logged for the checks
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (arr_wr_o) begin
			wr_cnt <= wr_cnt + 1;
			wr_addr <= arr_addr_o;
			wr_data <= arr_wdata_o;
		end
		if (cyc == 40000) begin
			num_errors = num_errors + 1;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] op);
		u_host.sel();
		u_host.xb(op, r);
		u_host.desel();
	endtask
	task automatic status_read_cmd();
		u_host.sel();
		u_host.xb(8'h05, r);
		u_host.xb(8'h00, r);
		u_host.desel();
	endtask
	task automatic idle();
		for (int i = 0; i < 600 && busy_o !== 1'b0; i++) @(posedge clk_i);
		chk(busy_o, 1'b0);
	endtask
	task automatic wst(input logic [7:0] v);
		cmd(8'h06);
		u_host.sel();
		u_host.xb(8'h01, r);
		u_host.xb(v, r);
		u_host.desel();
		idle();
	endtask
	task automatic addr(input logic [7:0] op, input logic [23:0] a);
		u_host.sel();
		u_host.xb(op, r);
		for (int i = 2; i >= 0; i--) u_host.xb(a[i*8+:8], r);
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk(status_o, 8'h00);
		chk(so_oe_n_o, 1'b1);
		cmd(8'hFF);
		status_read_cmd();
		chk(r, 8'h00);
		cmd(8'h06);
		status_read_cmd();
		chk(r, 8'h02);
		cmd(8'h04);
		status_read_cmd();
		chk(r, 8'h00);
		$display("test opcodes done");
		cmd(8'h06);
		addr(8'h02, 24'hFF1234);
		u_host.xb(8'hA5, r);
		u_host.xb(8'h3C, r);
		u_host.desel();
		chk(wr_cnt, 2);
		chk(wr_addr, 17'h11235);
		chk(wr_data, 8'h3C);
		chk(busy_o, 1'b1);
		status_read_cmd();
		chk(r[0], 1'b1);
		cmd(8'h06);
		idle();
		status_read_cmd();
		chk(r, 8'h00);
		$display("test write done");
		for (int m = 0; m < 2; m++) begin
			u_host.cpol = m[0];
			addr(8'h03, 24'h0001F0);
			u_host.xb(8'h00, r);
			chk(r, 8'hF0 ^ 8'hA5);
			u_host.pause();
			chk(so_oe_n_o, 1'b1);
			u_host.resume();
			u_host.xb(8'h00, r);
			chk(r, 8'hF1 ^ 8'hA5);
			u_host.desel();
		end
		u_host.cpol = 1'b0;
		$display("test read done");
		wst(8'hC0);
		status_read_cmd();
		chk(r, 8'hC0);
		wp_n_i <= 1'b0;
		wst(8'h00);
		status_read_cmd();
		chk(r & 8'hFC, 8'hC0);
		addr(8'h03, 24'h000010);
		u_host.xb(8'h00, r);
		chk(arr_id_page_o, 1'b1);
		u_host.desel();
		status_read_cmd();
		chk(r & 8'hFC, 8'h80);
		wp_n_i <= 1'b1;
		wst(8'h10);
		status_read_cmd();
		chk(r, 8'h10);
		wst(8'h40);
		cmd(8'h06);
		addr(8'h02, 24'h000005);
		u_host.xb(8'h11, r);
		u_host.desel();
		chk(wr_cnt, 2);
		wst(8'h08);
		cmd(8'h06);
		addr(8'h02, 24'h010000);
		u_host.xb(8'h22, r);
		u_host.desel();
		chk(wr_cnt, 2);
		cmd(8'h06);
		addr(8'h02, 24'h000100);
		u_host.xb(8'h33, r);
		u_host.desel();
		chk(wr_cnt, 3);
		chk(wr_addr, 17'h00100);
		chk(wr_data, 8'h33);
		$display("test protection done");
		end_of_test();
	end
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
endmodule

// File: testbench/spe_host.sv
module spe_host (
	input wire logic clk_i,
	input wire logic so_i,
	output logic sck_o,
	output logic cs_n_o,
	output logic si_o,
	output logic hold_n_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic cpol = 1'b0;
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
		hold_n_o = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// idle clock level is set while deselected so no stray edge lands in a frame
	task automatic sel();
		sck_o <= cpol;
		wt(4);
		cs_n_o <= 1'b0;
		wt(4);
	endtask
	task automatic desel();
		sck_o <= cpol;
		wt(4);
		cs_n_o <= 1'b1;
		si_o <= ~si_o;
		wt(8);
	endtask
	task automatic xb(input logic [7:0] o, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			sck_o <= 1'b0;
			si_o <= o[i];
			wt(4);
			sck_o <= 1'b1;
			wt(4);
			r[i] = so_i;
		end
	endtask
	task automatic pause();
		sck_o <= 1'b0;
		wt(4);
		hold_n_o <= 1'b0;
		wt(8);
	endtask
	task automatic resume();
		hold_n_o <= 1'b1;
		wt(4);
	endtask
endmodule
